// *** verilog/fpp_pkg.sv ***
package fpp_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W    = 8;     // 256 words
  localparam int DATA_W    = 4;     // four bits a word
  localparam int BIT_SEL_W = 2;

  // ****************************************************************
  // timing in their own units, then cycles at 100 MHz
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int LEAD_NS       = 100;   // program pin leads output pin
  localparam int D1_MIN_US     = 70;
  localparam int D1_MAX_US     = 90;
  localparam int D2_MIN_NS     = 100;
  localparam int PULSE_MIN_US  = 1;
  localparam int PULSE_MAX_US  = 40;
  localparam int DUTY_PCT      = 25;
  localparam int SETTLE_NS     = 100;   // verify read settle time

  // least times round up, longest round down
  localparam int LEAD_CYC  = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int D1_MIN_CYC =
    (D1_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int D1_MAX_CYC = (D1_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int D1_CYC     = (D1_MIN_CYC + D1_MAX_CYC) / 2;
  localparam int D2_CYC    = (D2_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC  =
    (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // off time so that pulse / cycle stays at or below the duty limit
  localparam int OFF_CYC =
    (PULSE_CYC * (100 - DUTY_PCT) + DUTY_PCT - 1) / DUTY_PCT;

  localparam int CNT_W = 16;

  // ****************************************************************
  // pulse levels and attempts
  // ****************************************************************
  localparam int          MAX_PULSES = 9;
  localparam int          STEP_LEN   = 3;
  localparam logic [1:0]  LVL_LOW    = 2'h0;   // 27 V / 20 V
  localparam logic [1:0]  LVL_MID    = 2'h1;   // 30 V / 23 V
  localparam logic [1:0]  LVL_HIGH   = 2'h2;   // 33 V / 26 V
  localparam logic        SUPPLY_LOW = 1'b0;   // 4.2 V, 12 mA load
  localparam logic        SUPPLY_HI  = 1'b1;   // 6.0 V, 0.2 mA load

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0]    addr;
    logic [BIT_SEL_W-1:0] bit_sel;
  } fpp_req_t;

  typedef struct packed {
    logic [1:0] level;
    logic       supply;
    logic       prog_pin;
    logic       out_pulse;
  } fpp_drive_t;

  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_SETUP  = 9'h002,
    S_LEAD   = 9'h004,
    S_WAIT1  = 9'h008,
    S_PULSE  = 9'h010,
    S_D2     = 9'h020,
    S_VERIFY = 9'h040,
    S_OFF    = 9'h080,
    S_DONE   = 9'h100
  } fpp_state_t;

endpackage

// *** verilog/fpp_sync.sv ***
`timescale 1ns/1ns
// ******************************************************************
// three-stage pin synchroniser, change taken when stages 2 and 3 agree
// ******************************************************************
module fpp_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // pin side
  input  wire logic [W-1:0] pin,
  // clean side
  output logic      [W-1:0] level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire  [W-1:0] agree = ~(s2 ^ s3);

  // s1 feeds only s2, so metastability stays out of the logic
  always_ff @(posedge clk) begin
    if (srst) begin
      s1    <= {W{1'b1}};
      s2    <= {W{1'b1}};
      s3    <= {W{1'b1}};
      level <= {W{1'b1}};
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= (agree & s3) | (~agree & level);
    end
  end

endmodule // fpp_sync

// *** verilog/fpp_prog.sv ***
`timescale 1ns/1ns
module fpp_prog (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // request: burn one bit to zero
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire fpp_pkg::fpp_req_t      req,
  // result
  output logic                        done,
  output logic                        fail,
  output logic [3:0]                  pulses_used,
  // device pins
  output logic [fpp_pkg::ADDR_W-1:0]  addr_pin,
  output logic                        prog_en_n,
  output logic                        other_en_n,
  output logic [fpp_pkg::DATA_W-1:0]  q_out,
  output logic [fpp_pkg::DATA_W-1:0]  q_oe,
  input  wire logic [fpp_pkg::DATA_W-1:0] q_in,
  // supply and level control to the analog front end
  output fpp_pkg::fpp_drive_t         drive
);

  // ****************************************************************
  // state
  // ****************************************************************
  fpp_pkg::fpp_state_t             state;
  fpp_pkg::fpp_state_t             next_state;
  logic [fpp_pkg::CNT_W-1:0]       cnt;
  logic [3:0]                      attempt;
  logic                            chk_hi;
  fpp_pkg::fpp_req_t               cur;
  logic [fpp_pkg::DATA_W-1:0]      q_sync;

  fpp_sync #(.W(fpp_pkg::DATA_W)) u_sync (
    .clk   (clk),
    .srst  (srst),
    .pin   (q_in),
    .level (q_sync)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [fpp_pkg::CNT_W-1:0] cyc(input int n);
    return fpp_pkg::CNT_W'(n - 1);
  endfunction

  // one-hot output select guarantees a single raised output
  function automatic logic [fpp_pkg::DATA_W-1:0] onehot(
    input logic [fpp_pkg::BIT_SEL_W-1:0] s);
    return fpp_pkg::DATA_W'(1) << s;
  endfunction

  // three pulses per level step
  function automatic logic [1:0] step_of(input logic [3:0] a);
    return (a < 4'h3) ? fpp_pkg::LVL_LOW :
           (a < 4'h6) ? fpp_pkg::LVL_MID : fpp_pkg::LVL_HIGH;
  endfunction

  // length of each phase, loaded into the counter on entry
  function automatic logic [fpp_pkg::CNT_W-1:0] phase_len(
    input fpp_pkg::fpp_state_t s);
    logic [fpp_pkg::CNT_W-1:0] n;
    n = '0;
    unique case (s)
      fpp_pkg::S_IDLE, fpp_pkg::S_DONE: n = '0;
      fpp_pkg::S_SETUP:  n = cyc(fpp_pkg::SETTLE_CYC);
      fpp_pkg::S_LEAD:   n = cyc(fpp_pkg::LEAD_CYC);
      fpp_pkg::S_WAIT1:  n = cyc(fpp_pkg::D1_CYC);
      fpp_pkg::S_PULSE:  n = cyc(fpp_pkg::PULSE_CYC);
      fpp_pkg::S_D2:     n = cyc(fpp_pkg::D2_CYC);
      fpp_pkg::S_VERIFY: n = cyc(fpp_pkg::SETTLE_CYC);
      fpp_pkg::S_OFF:    n = cyc(fpp_pkg::OFF_CYC);
    endcase
    return n;
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  wire cnt_done   = (cnt == '0);
  wire bit_low    = ~q_sync[cur.bit_sel];
  // attempt counts pulses given, so the ninth pulse is the last
  wire last_try   = (attempt == 4'(fpp_pkg::MAX_PULSES));
  // one request at a time; busy phases ignore req_valid
  wire take       = req_ready && req_valid;
  wire pulse_end  = (state == fpp_pkg::S_PULSE) && cnt_done;
  wire verify_end = (state == fpp_pkg::S_VERIFY) && cnt_done;
  wire bit_end    = verify_end && (next_state == fpp_pkg::S_DONE);
  wire next_pulse = (next_state == fpp_pkg::S_PULSE);
  // second supply corner reloads the count without a state change
  wire reload     = (next_state != state) || verify_end;
  wire [fpp_pkg::CNT_W-1:0] next_cnt =
    reload ? phase_len(next_state) : (cnt_done ? cnt : cnt - 1'b1);
  assign req_ready = (state == fpp_pkg::S_IDLE) ||
                     (state == fpp_pkg::S_DONE);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      fpp_pkg::S_IDLE, fpp_pkg::S_DONE:
        if (req_valid) next_state = fpp_pkg::S_SETUP;
      fpp_pkg::S_SETUP:  if (cnt_done) next_state = fpp_pkg::S_LEAD;
      fpp_pkg::S_LEAD:   if (cnt_done) next_state = fpp_pkg::S_WAIT1;
      fpp_pkg::S_WAIT1:  if (cnt_done) next_state = fpp_pkg::S_PULSE;
      fpp_pkg::S_PULSE:  if (cnt_done) next_state = fpp_pkg::S_D2;
      fpp_pkg::S_D2:     if (cnt_done) next_state = fpp_pkg::S_VERIFY;
      fpp_pkg::S_VERIFY:
        if (cnt_done) begin
          if (!bit_low) next_state = last_try ? fpp_pkg::S_DONE
                                              : fpp_pkg::S_OFF;
          else if (chk_hi) next_state = fpp_pkg::S_DONE;
        end
      fpp_pkg::S_OFF:    if (cnt_done) next_state = fpp_pkg::S_LEAD;
    endcase
  end

  // phase counter reloads on every state entry and at verify end, else counts down and holds at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= fpp_pkg::S_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // request capture, attempt count, supply corner
  always_ff @(posedge clk) begin
    if (srst) begin
      cur     <= '0;
      attempt <= '0;
      chk_hi  <= 1'b0;
    end else begin
      if (take) begin
        cur     <= req;
        attempt <= '0;
      end
      if (pulse_end)
        attempt <= attempt + 1'b1;
      // verify at low supply first, then high
      if (verify_end)
        chk_hi <= bit_low && !chk_hi;
      else if (state != fpp_pkg::S_VERIFY)
        chk_hi <= 1'b0;
    end
  end

  // result flags; a blank part reads all ones until burnt
  always_ff @(posedge clk) begin
    if (srst) begin
      done        <= 1'b0;
      fail        <= 1'b0;
      pulses_used <= '0;
    end else begin
      done <= 1'b0;
      if (take)
        fail <= 1'b0;
      if (bit_end) begin
        done        <= 1'b1;
        fail        <= !bit_low;
        pulses_used <= attempt;
      end
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  wire pin_active = (state == fpp_pkg::S_LEAD) ||
                    (state == fpp_pkg::S_WAIT1) ||
                    (state == fpp_pkg::S_PULSE);
  wire verifying  = (state == fpp_pkg::S_VERIFY);

  // registered pins; address held whole sequence for clean decode
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_pin   <= '0;
      prog_en_n  <= 1'b1;
      other_en_n <= 1'b1;
      q_out      <= '0;
      q_oe       <= '0;
      drive      <= '0;
    end else begin
      addr_pin        <= cur.addr;
      // program enable held high disables outputs through the pulse; low only in verify
      prog_en_n       <= !verifying;
      // other enable tied to program enable position
      other_en_n      <= !verifying;
      // logic level stays low; the front end sets the pulse height
      q_out           <= '0;
      q_oe            <= next_pulse ? onehot(cur.bit_sel) : '0;
      drive.prog_pin  <= pin_active;
      drive.out_pulse <= next_pulse;
      drive.level     <= step_of(attempt);
      drive.supply    <= chk_hi ? fpp_pkg::SUPPLY_HI
                                : fpp_pkg::SUPPLY_LOW;
    end
  end

endmodule // fpp_prog

// *** bench/fpp_prog_sva.sv ***
`timescale 1ns/1ns
module fpp_prog_sva (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       srst,
  // request side
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire logic                       done,
  input wire logic                       fail,
  input wire logic [3:0]                 pulses_used,
  // device pins
  input wire logic [fpp_pkg::ADDR_W-1:0] addr_pin,
  input wire logic                       prog_en_n,
  input wire logic                       other_en_n,
  input wire logic [fpp_pkg::DATA_W-1:0] q_out,
  input wire logic [fpp_pkg::DATA_W-1:0] q_oe,
  input wire fpp_pkg::fpp_drive_t        drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [15:0] dis_cnt, low_cnt, hi_cnt, hi_last;
  logic [3:0]  att;
  logic        op_d;
  wire         rise_p = drive.out_pulse && !op_d;
  // ****************************************************************
  // helper counters
  // ****************************************************************
  // disable time restarts on a taken request, since idle is disabled too
  always_ff @(posedge clk) begin
    if (srst) begin
      {dis_cnt, low_cnt, hi_cnt, hi_last, att, op_d} <= '0;
    end else begin
      op_d    <= drive.out_pulse;
      dis_cnt <= (!prog_en_n || (req_valid && req_ready)) ? 16'h0
                 : dis_cnt + 16'h1;
      low_cnt <= drive.out_pulse ? 16'h0
                 : low_cnt + {15'h0, low_cnt != 16'hffff};
      hi_cnt  <= drive.out_pulse ? hi_cnt + 16'h1 : 16'h0;
      if (op_d && !drive.out_pulse) hi_last <= hi_cnt;
      if (req_valid && req_ready) att <= 4'h0;
      else if (rise_p) att <= att + 4'h1;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_one_out;
    q_oe != 4'h0 |-> $onehot(q_oe) && prog_en_n && drive.prog_pin
      && $stable(addr_pin) && q_out == 4'h0;
  endproperty
  a_one_out: assert property (p_one_out)
    else $error("output pulse not single or not qualified");
  property p_lead;
    rise_p |-> drive.prog_pin && $past(drive.prog_pin, 10);
  endproperty
  a_lead: assert property (p_lead)
    else $error("program pin does not lead output pulse");
  property p_d1;
    rise_p |-> dis_cnt >= fpp_pkg::D1_MIN_CYC
      && dis_cnt <= fpp_pkg::D1_MAX_CYC;
  endproperty
  a_d1: assert property (p_d1)
    else $error("disable to pulse delay out of range");
  property p_d2;
    $fell(prog_en_n) |-> low_cnt >= fpp_pkg::D2_CYC;
  endproperty
  a_d2: assert property (p_d2)
    else $error("enable too soon after pulse");
  property p_duty;
    rise_p |-> low_cnt >= 3 * hi_last;
  endproperty
  a_duty: assert property (p_duty)
    else $error("pulse duty above limit");
  property p_tie;
    other_en_n == prog_en_n && (prog_en_n || !drive.out_pulse);
  endproperty
  a_tie: assert property (p_tie)
    else $error("enables differ or pulse while enabled");
  property p_level;
    rise_p |-> drive.level == 2'(att / 4'h3);
  endproperty
  a_level: assert property (p_level)
    else $error("pulse level step wrong");
  property p_cap;
    rise_p |-> att < 4'h9;
  endproperty
  a_cap: assert property (p_cap)
    else $error("more than nine pulses on one bit");
  property p_done;
    done |-> pulses_used == att && att != 4'h0;
  endproperty
  a_done: assert property (p_done)
    else $error("reported pulse count wrong");
  property p_supply;
    done && !fail |-> $past(drive.supply) == fpp_pkg::SUPPLY_HI
      && $past(prog_en_n) == 1'b0;
  endproperty
  a_supply: assert property (p_supply)
    else $error("bit passed without a high supply check");
  property p_supply_lo;
    $fell(prog_en_n) |-> drive.supply == fpp_pkg::SUPPLY_LOW;
  endproperty
  a_supply_lo: assert property (p_supply_lo)
    else $error("verify did not start at low supply");
  c_high: cover property (rise_p && drive.level == fpp_pkg::LVL_HIGH);
  c_retry: cover property (rise_p && att == 4'h1);
  c_done: cover property (done && pulses_used == 4'h9);
endmodule // fpp_prog_sva

bind fpp_prog fpp_prog_sva u_fpp_prog_sva (.clk, .srst, .req_valid,
  .req_ready, .done, .fail, .pulses_used, .addr_pin, .prog_en_n,
  .other_en_n, .q_out, .q_oe, .drive);

// *** bench/fpp_dev_model.sv ***
`timescale 1ns/1ns
module fpp_dev_model (
  // clock
  input wire logic       clk,
  // device pins
  input wire logic [7:0] addr,
  input wire logic       en_a_n,
  input wire logic       en_b_n,
  input wire logic       prog_pin,
  input wire logic [3:0] raised,
  // fuse hardness: pulses needed to blow
  input wire logic [3:0] need,
  output logic [3:0]     q
);
  logic [3:0] mem [256];
  logic [3:0] hits [256][4];
  logic [3:0] raised_d;
  // blank part: every location reads ones
  initial begin
    raised_d = 4'h0;
    foreach (mem[i]) mem[i] = 4'hf;
    foreach (hits[i, j]) hits[i][j] = 4'h0;
  end
  // a fuse blows on the nth raised pulse; zero never returns to one
  always @(posedge clk) begin
    raised_d <= raised;
    if (en_a_n && prog_pin && $onehot(raised) && raised_d == 4'h0)
      for (int b = 0; b < 4; b++)
        if (raised[b]) begin
          hits[addr][b] = hits[addr][b] + 4'h1;
          if (hits[addr][b] >= need) mem[addr][b] = 1'b0;
        end
  end
  // open collector: off reads high through the pull-up
  assign q = (!en_a_n && !en_b_n) ? mem[addr] : 4'hf;
endmodule // fpp_dev_model

// *** bench/fpp_prog_tb.sv ***
`timescale 1ns/1ns
module fpp_prog_tb;
  logic clk, srst, req_valid, req_ready, done, fail, prog_en_n, other_en_n;
  logic [3:0] pulses_used, q_out, q_oe, q_in, dev_q, need;
  logic [7:0] addr_pin, a;
  logic [3:0] shadow [256];
  fpp_pkg::fpp_req_t   req;
  fpp_pkg::fpp_drive_t drive;
  int fail_count, check_count, seed, cycles;
  // wire level: controller drives only where enabled
  assign q_in = (q_oe & q_out) | (~q_oe & dev_q);
  fpp_prog u_fpp_prog (.clk, .srst, .req_valid, .req_ready, .req, .done,
    .fail, .pulses_used, .addr_pin, .prog_en_n, .other_en_n, .q_out,
    .q_oe, .q_in, .drive);
  fpp_dev_model u_fpp_dev_model (.clk, .addr(addr_pin), .en_a_n(prog_en_n),
    .en_b_n(other_en_n), .prog_pin(drive.prog_pin),
    .raised(q_oe & {4{drive.out_pulse}}), .need, .q(dev_q));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard: whole run needs about 100.3k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 103000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] exp_pulses(input logic [3:0] n);
    return (n > 4'h9) ? 4'h9 : n;
  endfunction
  // one bit burn; fuses harder than nine pulses must be reported
  task automatic burn(input logic [7:0] wa, input logic [1:0] b,
                      input logic [3:0] n);
    logic [3:0] w;
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{addr: wa, bit_sel: b};
    need      <= n;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    do @(negedge clk); while (done !== 1'b1);
    w = shadow[wa];
    if (n <= 4'h9) w[b] = 1'b0;
    shadow[wa] = w;
    check(fail, n > 4'h9);
    check(pulses_used, exp_pulses(n));
    check(u_fpp_dev_model.mem[wa], w);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {req_valid, req, need} = '0;
    srst = 1'b1;
    foreach (shadow[i]) shadow[i] = 4'hf;
    seed = 80560;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    a = 8'($random(seed));
    burn(a, 2'($random(seed)), 4'h1);
    // back to back, neighbour bit of the same word, needs a retry
    burn(a, req.bit_sel ^ 2'h1, 4'h2);
    // fuse never blows: all three level steps, then failure
    burn(~a, 2'($random(seed)), 4'ha);
    final_report();
  end
endmodule // fpp_prog_tb
